// >>> include/rgc_pkg.sv
// Package for the gigabit MAC interface configuration register block.
`default_nettype none
package rgc_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    // Printed offset is not word aligned, so it is kept as an index.
    localparam logic [17:0] RGC_CFG_INDEX    = 18'h0FF23;
    localparam logic [17:0] RGC_CFG_BYTEADDR = 18'(RGC_CFG_INDEX * 4);
    localparam logic [15:0] RGC_CFG_RESET    = 16'h0E07;
    localparam logic [4:0]  RGC_RSVD_RESET   = 5'h01;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int RGC_FAST_LL_POS = 10;
    localparam int RGC_SLOW_LL_POS = 9;
    localparam int RGC_RX_SEL_LSB  = 6;
    localparam int RGC_TX_SEL_LSB  = 3;
    localparam int RGC_RX_FIX_POS  = 2;
    localparam int RGC_TX_FIX_POS  = 1;
    localparam int RGC_MODE_POS    = 0;

    // ************************************************************
    // Delay encoding and timing
    // ************************************************************
    localparam int          RGC_UNIT_PS      = 200;
    localparam int          RGC_OFFSET_PS    = 400;
    localparam int          RGC_FIXED_DLY_PS = 2000;
    localparam logic [3:0]  RGC_UNITS_DEFAULT = 4'h8;
    localparam logic [1:0]  RGC_STRAP_SETTLE  = 2'h2;

    localparam logic [1:0]  RGC_RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RGC_RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [4:0] reserved;
        logic       fast_speed_low_latency_enable;
        logic       slow_speed_low_latency_enable;
        logic [2:0] receive_clock_delay_select;
        logic [2:0] transmit_clock_delay_select;
        logic       receive_fixed_delay_enable;
        logic       transmit_fixed_delay_enable;
        logic       gigabit_mac_mode_select;
    } rgc_cfg_t;

    typedef struct packed {
        logic [3:0] units;
        logic       reserved_code;
    } rgc_delay_t;

endpackage : rgc_pkg
`default_nettype wire

// >>> hdl/rgc_config.sv
// Gigabit MAC interface configuration register with AXI4-Lite access.
`timescale 1ns/1ps
`default_nettype none
module rgc_config
    import rgc_pkg::*;
#(
    parameter int ADDR_W = 18
) (
    input  wire logic              REF_CLK_I,          // 25 MHz clock
    input  wire logic              RESET_N_I,          // Sync reset, active low
    input  wire logic              STRAP_RX_FIX_I,     // Strap: rx fixed delay
    input  wire logic              STRAP_TX_FIX_I,     // Strap: tx fixed delay
    input  wire logic              STRAP_MODE_I,       // Strap: gigabit mode
    input  wire logic [ADDR_W-1:0] S_AXI_AWADDR_I,     // Write address
    input  wire logic              S_AXI_AWVALID_I,    // Write address valid
    output logic                   S_AXI_AWREADY_O,    // Write address ready
    input  wire logic [31:0]       S_AXI_WDATA_I,      // Write data
    input  wire logic [3:0]        S_AXI_WSTRB_I,      // Write strobes
    input  wire logic              S_AXI_WVALID_I,     // Write data valid
    output logic                   S_AXI_WREADY_O,     // Write data ready
    output logic [1:0]             S_AXI_BRESP_O,      // Write response
    output logic                   S_AXI_BVALID_O,     // Write response valid
    input  wire logic              S_AXI_BREADY_I,     // Write response ready
    input  wire logic [ADDR_W-1:0] S_AXI_ARADDR_I,     // Read address
    input  wire logic              S_AXI_ARVALID_I,    // Read address valid
    output logic                   S_AXI_ARREADY_O,    // Read address ready
    output logic [31:0]            S_AXI_RDATA_O,      // Read data
    output logic [1:0]             S_AXI_RRESP_O,      // Read response
    output logic                   S_AXI_RVALID_O,     // Read data valid
    input  wire logic              S_AXI_RREADY_I,     // Read data ready
    output logic                   FAST_LOW_LAT_EN_O,  // 100 Mbps low latency
    output logic                   SLOW_LOW_LAT_EN_O,  // 10 Mbps low latency
    output logic [3:0]             RX_DELAY_UNITS_O,   // Rx delay in units
    output logic                   RX_DELAY_RSVD_O,    // Rx code is reserved
    output logic [3:0]             TX_DELAY_UNITS_O,   // Tx delay in units
    output logic                   TX_DELAY_RSVD_O,    // Tx code is reserved
    output logic                   RX_FIXED_DELAY_O,   // Rx fixed 2 ns delay
    output logic                   TX_FIXED_DELAY_O,   // Tx fixed 2 ns delay
    output logic                   GIGABIT_MODE_O      // Gigabit mode select
);

    // ************************************************************
    // Elaboration checks
    // ************************************************************
    // The mapped byte address needs all 18 bits; wider buses only add zeros
    if (ADDR_W < 18 || ADDR_W > 32) begin : g_bad_addr_w
        $error("ADDR_W must be 18 to 32");
    end

    // The stored view must be exactly one 16-bit register
    if ($bits(rgc_cfg_t) != 16) begin : g_bad_cfg_width
        $error("rgc_cfg_t must be 16 bits wide");
    end

    // The read-only top bits are forced on every write, so both constants must agree
    if (RGC_CFG_RESET[15:11] != RGC_RSVD_RESET) begin : g_bad_rsvd
        $error("RGC_RSVD_RESET must match the top bits of RGC_CFG_RESET");
    end

    // Capture must wait at least as long as the two-stage sync pipe
    if (RGC_STRAP_SETTLE < 2'h2) begin : g_bad_settle
        $error("RGC_STRAP_SETTLE must cover the two sync stages");
    end

    // ************************************************************
    // Delay code decode
    // ************************************************************
    function automatic rgc_delay_t decode_delay(input logic [2:0] code);
        rgc_delay_t d;
        d.reserved_code = 1'b0;
        unique case (code)
            3'h0: d.units = 4'h8;
            3'h1: d.units = 4'h6;
            3'h2: d.units = 4'h7;
            3'h6: d.units = 4'h9;
            3'h7: d.units = 4'hA;
            default: begin
                // Reserved codes fall back to the reset delay so the line stays sane
                d.units         = RGC_UNITS_DEFAULT;
                d.reserved_code = 1'b1;
            end
        endcase
        return d;
    endfunction : decode_delay

    function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
        return a == ADDR_W'(RGC_CFG_BYTEADDR);
    endfunction : addr_hit

    // ************************************************************
    // Strap capture
    // ************************************************************
    logic [2:0] strap_meta_ff;
    logic [2:0] strap_sync_ff;
    logic [1:0] settle_ff;
    logic       loading_ff;

    // Straps are pins, so they are synchronised and left unreset
    always_ff @(posedge REF_CLK_I) begin
        strap_meta_ff <= {STRAP_RX_FIX_I, STRAP_TX_FIX_I, STRAP_MODE_I};
        strap_sync_ff <= strap_meta_ff;
    end

    // Wait for the sync pipe to fill after release before taking the straps
    always_ff @(posedge REF_CLK_I) begin
        if (!RESET_N_I) begin
            settle_ff  <= 2'h0;
            loading_ff <= 1'b1;
        end else if (loading_ff) begin
            settle_ff <= settle_ff + 2'h1;
            if (settle_ff == RGC_STRAP_SETTLE) begin
                loading_ff <= 1'b0;
            end
        end
    end

    // ************************************************************
    // AXI4-Lite write channel
    // ************************************************************
    logic              aw_held_ff;
    logic [ADDR_W-1:0] aw_addr_ff;
    logic              w_held_ff;
    logic [31:0]       w_data_ff;
    logic [3:0]        w_strb_ff;
    logic              bvalid_ff;
    logic [1:0]        bresp_ff;
    logic              do_write;

    assign S_AXI_AWREADY_O = !aw_held_ff && !bvalid_ff && !loading_ff;
    assign S_AXI_WREADY_O  = !w_held_ff && !bvalid_ff && !loading_ff;
    assign S_AXI_BVALID_O  = bvalid_ff;
    assign S_AXI_BRESP_O   = bresp_ff;
    assign do_write        = aw_held_ff && w_held_ff && !bvalid_ff;

    // Address and data are held until both are in, so they may arrive in either order

    always_ff @(posedge REF_CLK_I) begin
        if (!RESET_N_I) begin
            aw_held_ff <= 1'b0;
            aw_addr_ff <= '0;
        end else if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
            aw_held_ff <= 1'b1;
            aw_addr_ff <= S_AXI_AWADDR_I;
        end else if (do_write) begin
            aw_held_ff <= 1'b0;
        end
    end

    always_ff @(posedge REF_CLK_I) begin
        if (!RESET_N_I) begin
            w_held_ff <= 1'b0;
            w_data_ff <= 32'h0000_0000;
            w_strb_ff <= 4'h0;
        end else if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
            w_held_ff <= 1'b1;
            w_data_ff <= S_AXI_WDATA_I;
            w_strb_ff <= S_AXI_WSTRB_I;
        end else if (do_write) begin
            w_held_ff <= 1'b0;
        end
    end

    always_ff @(posedge REF_CLK_I) begin
        if (!RESET_N_I) begin
            bvalid_ff <= 1'b0;
            bresp_ff  <= RGC_RESP_OKAY;
        end else if (do_write) begin
            bvalid_ff <= 1'b1;
            bresp_ff  <= addr_hit(aw_addr_ff) ? RGC_RESP_OKAY : RGC_RESP_SLVERR;
        end else if (bvalid_ff && S_AXI_BREADY_I) begin
            bvalid_ff <= 1'b0;
        end
    end

    // ************************************************************
    // Configuration register
    // ************************************************************
    rgc_cfg_t    cfg_ff;
    logic [15:0] nxt_cfg;

    // Byte lanes select the halves; the read-only top bits are put back on every write
    always_comb begin
        nxt_cfg = cfg_ff;
        if (w_strb_ff[0]) begin
            nxt_cfg[7:0] = w_data_ff[7:0];
        end
        if (w_strb_ff[1]) begin
            nxt_cfg[15:8] = w_data_ff[15:8];
        end
        nxt_cfg[15:11] = RGC_RSVD_RESET;
    end

    always_ff @(posedge REF_CLK_I) begin
        if (!RESET_N_I) begin
            cfg_ff <= rgc_cfg_t'(RGC_CFG_RESET);
        end else if (loading_ff) begin
            if (settle_ff == RGC_STRAP_SETTLE) begin
                cfg_ff.receive_fixed_delay_enable  <= strap_sync_ff[2];
                cfg_ff.transmit_fixed_delay_enable <= strap_sync_ff[1];
                cfg_ff.gigabit_mac_mode_select     <= strap_sync_ff[0];
            end
        end else if (do_write && addr_hit(aw_addr_ff)) begin
            cfg_ff <= rgc_cfg_t'(nxt_cfg);
        end
    end

    // ************************************************************
    // AXI4-Lite read channel
    // ************************************************************
    logic        rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0]  rresp_ff;
    logic [31:0] nxt_rdata;
    logic [1:0]  nxt_rresp;

    assign S_AXI_ARREADY_O = !rvalid_ff && !loading_ff;
    assign S_AXI_RVALID_O  = rvalid_ff;
    assign S_AXI_RDATA_O   = rdata_ff;
    assign S_AXI_RRESP_O   = rresp_ff;

    // Unmapped reads answer with an error and zero data instead of aliasing the register
    always_comb begin
        nxt_rdata = 32'h0000_0000;
        nxt_rresp = RGC_RESP_SLVERR;
        if (addr_hit(S_AXI_ARADDR_I)) begin
            nxt_rdata = {16'h0000, cfg_ff};
            nxt_rresp = RGC_RESP_OKAY;
        end
    end

    // A read taken on a commit edge still returns the value from before the write
    always_ff @(posedge REF_CLK_I) begin
        if (!RESET_N_I) begin
            rvalid_ff <= 1'b0;
            rdata_ff  <= 32'h0000_0000;
            rresp_ff  <= RGC_RESP_OKAY;
        end else if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
            rvalid_ff <= 1'b1;
            rdata_ff  <= nxt_rdata;
            rresp_ff  <= nxt_rresp;
        end else if (rvalid_ff && S_AXI_RREADY_I) begin
            rvalid_ff <= 1'b0;
        end
    end

    // ************************************************************
    // Configuration outputs toward the MAC interface logic
    // ************************************************************
    rgc_delay_t rx_dly_ff;
    rgc_delay_t tx_dly_ff;
    logic [4:0] ctl_ff;

    // Registered a cycle behind the register to keep the decode off the output pins
    always_ff @(posedge REF_CLK_I) begin
        if (!RESET_N_I) begin
            rx_dly_ff <= '{units: RGC_UNITS_DEFAULT, reserved_code: 1'b0};
        end else begin
            rx_dly_ff <= decode_delay(cfg_ff.receive_clock_delay_select);
        end
    end

    // Reserved codes are the software's to avoid; here they raise the flag and fall back to RGC_UNITS_DEFAULT
    always_ff @(posedge REF_CLK_I) begin
        if (!RESET_N_I) begin
            tx_dly_ff <= '{units: RGC_UNITS_DEFAULT, reserved_code: 1'b0};
        end else begin
            tx_dly_ff <= decode_delay(cfg_ff.transmit_clock_delay_select);
        end
    end

    always_ff @(posedge REF_CLK_I) begin
        if (!RESET_N_I) begin
            ctl_ff <= {RGC_CFG_RESET[RGC_FAST_LL_POS], RGC_CFG_RESET[RGC_SLOW_LL_POS],
                       RGC_CFG_RESET[RGC_RX_FIX_POS], RGC_CFG_RESET[RGC_TX_FIX_POS],
                       RGC_CFG_RESET[RGC_MODE_POS]};
        end else begin
            ctl_ff <= {cfg_ff.fast_speed_low_latency_enable,
                       cfg_ff.slow_speed_low_latency_enable,
                       cfg_ff.receive_fixed_delay_enable,
                       cfg_ff.transmit_fixed_delay_enable,
                       cfg_ff.gigabit_mac_mode_select};
        end
    end

    assign FAST_LOW_LAT_EN_O = ctl_ff[4];
    assign SLOW_LOW_LAT_EN_O = ctl_ff[3];
    assign RX_FIXED_DELAY_O  = ctl_ff[2];
    assign TX_FIXED_DELAY_O  = ctl_ff[1];
    assign GIGABIT_MODE_O    = ctl_ff[0];
    assign RX_DELAY_UNITS_O  = rx_dly_ff.units;
    assign RX_DELAY_RSVD_O   = rx_dly_ff.reserved_code;
    assign TX_DELAY_UNITS_O  = tx_dly_ff.units;
    assign TX_DELAY_RSVD_O   = tx_dly_ff.reserved_code;

endmodule : rgc_config
`default_nettype wire

// >>> verification/rgc_mac_model.sv
// Behavioural model of the MAC side that reads the configured clock skew.
`timescale 1ns/1ps
`default_nettype none
module rgc_mac_model
    import rgc_pkg::*;
(
    input  wire logic [3:0]  rx_units_i, // Rx delay units
    input  wire logic [3:0]  tx_units_i, // Tx delay units
    input  wire logic        rx_fix_i,   // Rx fixed delay on
    input  wire logic        tx_fix_i,   // Tx fixed delay on
    output logic      [15:0] rx_ps_o,    // Rx clock skew in ps
    output logic      [15:0] tx_ps_o     // Tx clock skew in ps
);
    // Skew the MAC must budget for: unit steps, base offset and the fixed delay
    assign rx_ps_o = 16'(int'(rx_units_i) * RGC_UNIT_PS + RGC_OFFSET_PS
                         + int'(rx_fix_i) * RGC_FIXED_DLY_PS);
    assign tx_ps_o = 16'(int'(tx_units_i) * RGC_UNIT_PS + RGC_OFFSET_PS
                         + int'(tx_fix_i) * RGC_FIXED_DLY_PS);
endmodule : rgc_mac_model
`default_nettype wire

// >>> verification/rgc_config_monitor.sv
// Bound checker for the gigabit MAC interface configuration register.
`timescale 1ns/1ps
`default_nettype none
module rgc_config_monitor
    import rgc_pkg::*;
(
    input wire logic        REF_CLK_I,         // Clock
    input wire logic        RESET_N_I,         // Reset
    input wire logic [31:0] S_AXI_WDATA_I,     // W data
    input wire logic [3:0]  S_AXI_WSTRB_I,     // W strobes
    input wire logic        S_AXI_WVALID_I,    // W valid
    input wire logic        S_AXI_WREADY_O,    // W ready
    input wire logic [1:0]  S_AXI_BRESP_O,     // B resp
    input wire logic        S_AXI_BVALID_O,    // B valid
    input wire logic [31:0] S_AXI_RDATA_O,     // R data
    input wire logic [1:0]  S_AXI_RRESP_O,     // R resp
    input wire logic        S_AXI_RVALID_O,    // R valid
    input wire logic        FAST_LOW_LAT_EN_O, // 100M low latency
    input wire logic        SLOW_LOW_LAT_EN_O, // 10M low latency
    input wire logic [3:0]  RX_DELAY_UNITS_O,  // Rx units
    input wire logic        RX_DELAY_RSVD_O,   // Rx reserved
    input wire logic [3:0]  TX_DELAY_UNITS_O,  // Tx units
    input wire logic        TX_DELAY_RSVD_O,   // Tx reserved
    input wire logic        RX_FIXED_DELAY_O,  // Rx fixed
    input wire logic        TX_FIXED_DELAY_O,  // Tx fixed
    input wire logic        GIGABIT_MODE_O     // Mode
);
    logic [15:0] wd_ff;
    logic [3:0]  ws_ff;
    default clocking @(posedge REF_CLK_I); endclocking
    default disable iff (!RESET_N_I);
    // Last accepted write data; only one write is outstanding at a time
    always_ff @(posedge REF_CLK_I) begin
        if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
            wd_ff <= S_AXI_WDATA_I[15:0];
            ws_ff <= S_AXI_WSTRB_I;
        end
    end
    function automatic logic [4:0] dec(input logic [2:0] c);
        case (c)
            3'h0: dec = 5'h08;
            3'h1: dec = 5'h06;
            3'h2: dec = 5'h07;
            3'h6: dec = 5'h09;
            3'h7: dec = 5'h0A;
            default: dec = 5'h18;
        endcase
    endfunction : dec
    sequence s_wr;
        $rose(S_AXI_BVALID_O) && S_AXI_BRESP_O == RGC_RESP_OKAY && ws_ff == 4'hF;
    endsequence
    property p_fast; s_wr |-> ##1 FAST_LOW_LAT_EN_O == wd_ff[10]; endproperty
    a_fast: assert property (p_fast) else $error("fast low latency wrong");
    property p_slow; s_wr |=> SLOW_LOW_LAT_EN_O == wd_ff[9]; endproperty
    a_slow: assert property (p_slow) else $error("slow low latency wrong");
    property p_rx; s_wr |-> ##1 {RX_DELAY_RSVD_O, RX_DELAY_UNITS_O} == dec(wd_ff[8:6]); endproperty
    a_rx: assert property (p_rx) else $error("rx delay decode wrong");
    property p_tx; s_wr |-> ##1 {TX_DELAY_RSVD_O, TX_DELAY_UNITS_O} == dec(wd_ff[5:3]); endproperty
    a_tx: assert property (p_tx) else $error("tx delay decode wrong");
    property p_rxf; s_wr |=> RX_FIXED_DELAY_O == wd_ff[2]; endproperty
    a_rxf: assert property (p_rxf) else $error("rx fixed delay wrong");
    property p_txf; s_wr |=> TX_FIXED_DELAY_O == wd_ff[1]; endproperty
    a_txf: assert property (p_txf) else $error("tx fixed delay wrong");
    property p_mode; s_wr |-> ##1 GIGABIT_MODE_O == wd_ff[0] [*2]; endproperty
    a_mode: assert property (p_mode) else $error("mode select wrong");
    property p_rsvd;
        S_AXI_RVALID_O && S_AXI_RRESP_O == RGC_RESP_OKAY |-> S_AXI_RDATA_O[31:11] == 21'h000001;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("read only bits wrong");
endmodule : rgc_config_monitor
bind rgc_config rgc_config_monitor i_mon (.*);
`default_nettype wire

// >>> verification/rgc_config_bench.sv
// Self-checking bench for the gigabit MAC interface configuration register.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fails++; \
    $display("BAD %s expected %h seen %h", nm, (e), (g)); end end
module rgc_config_bench
    import rgc_pkg::*;
;
    logic        clk = 1'b0, rst_n = 1'b0, s_rx = 1'b0, s_tx = 1'b1, s_md = 1'b0;
    logic [17:0] awaddr = 18'h00000, araddr = 18'h00000;
    logic [31:0] wdata = 32'h00000000, rdata, d;
    logic [3:0]  wstrb = 4'h0, rx_u, tx_u;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, fast, slow, rx_rs, tx_rs;
    logic        rx_fx, tx_fx, mode;
    logic [1:0]  bresp, rresp, r;
    logic [15:0] rx_ps, tx_ps, v;
    logic [2:0]  codes [5] = '{3'h0, 3'h1, 3'h2, 3'h6, 3'h7};
    int          fails = 0, n_tests = 0, cyc = 0, i;
    always #20 clk = ~clk;
    rgc_config i_dut (.REF_CLK_I(clk), .RESET_N_I(rst_n), .STRAP_RX_FIX_I(s_rx),
        .STRAP_TX_FIX_I(s_tx), .STRAP_MODE_I(s_md), .S_AXI_AWADDR_I(awaddr),
        .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata),
        .S_AXI_WSTRB_I(wstrb), .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready),
        .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
        .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready),
        .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid),
        .S_AXI_RREADY_I(rready), .FAST_LOW_LAT_EN_O(fast), .SLOW_LOW_LAT_EN_O(slow),
        .RX_DELAY_UNITS_O(rx_u), .RX_DELAY_RSVD_O(rx_rs), .TX_DELAY_UNITS_O(tx_u),
        .TX_DELAY_RSVD_O(tx_rs), .RX_FIXED_DELAY_O(rx_fx), .TX_FIXED_DELAY_O(tx_fx),
        .GIGABIT_MODE_O(mode));
    rgc_mac_model i_mac (.rx_units_i(rx_u), .tx_units_i(tx_u), .rx_fix_i(rx_fx),
        .tx_fix_i(tx_fx), .rx_ps_o(rx_ps), .tx_ps_o(tx_ps));
    task automatic end_sim;
        if (fails == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : end_sim
    // Ready is combinational, so it is judged mid-cycle where it has settled
    task automatic wr(input logic [17:0] a, input logic [31:0] dt, input logic [3:0] s,
                      output logic [1:0] rs);
        logic pa, pw, pb, ka, kw;
        pa = 1'b1;
        pw = 1'b1;
        pb = 1'b1;
        @(posedge clk);
        awaddr  <= a;
        wdata   <= dt;
        wstrb   <= s;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        while (pb) begin
            @(negedge clk);
            ka = pa && awready;
            kw = pw && wready;
            if (bvalid && !pa && !pw) begin
                rs = bresp;
                pb = 1'b0;
            end
            @(posedge clk);
            if (ka) begin
                awvalid <= 1'b0;
                pa = 1'b0;
            end
            if (kw) begin
                wvalid <= 1'b0;
                pw = 1'b0;
            end
            if (!pb) begin
                bready <= 1'b0;
            end
        end
    endtask : wr
    task automatic rd(input logic [17:0] a, output logic [31:0] dt, output logic [1:0] rs);
        logic pa, pr, ka;
        pa = 1'b1;
        pr = 1'b1;
        @(posedge clk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        while (pr) begin
            @(negedge clk);
            ka = pa && arready;
            if (rvalid && !pa) begin
                dt = rdata;
                rs = rresp;
                pr = 1'b0;
            end
            @(posedge clk);
            if (ka) begin
                arvalid <= 1'b0;
                pa = 1'b0;
            end
            if (!pr) begin
                rready <= 1'b0;
            end
        end
    endtask : rd
    task automatic chk_reg(input logic [15:0] e);
        logic [31:0] dd;
        logic [1:0]  rr;
        logic [3:0]  ur, ut;
        logic [15:0] pr, pt;
        rd(RGC_CFG_BYTEADDR, dd, rr);
        ur = (e[8:6] == 3'h0) ? 4'h8 : (e[8:6] < 3'h3) ? 4'(e[8:6]) + 4'h5 : 4'(e[8:6]) + 4'h3;
        ut = (e[5:3] == 3'h0) ? 4'h8 : (e[5:3] < 3'h3) ? 4'(e[5:3]) + 4'h5 : 4'(e[5:3]) + 4'h3;
        pr = {12'h000, ur} * 16'h00C8 + 16'h0190 + (e[2] ? 16'h07D0 : 16'h0000);
        pt = {12'h000, ut} * 16'h00C8 + 16'h0190 + (e[1] ? 16'h07D0 : 16'h0000);
        `CHK("rresp", RGC_RESP_OKAY, rr)
        `CHK("rdata", {16'h0000, e}, dd)
        `CHK("fast", e[10], fast)
        `CHK("slow", e[9], slow)
        `CHK("rx_units", {1'b0, ur}, {rx_rs, rx_u})
        `CHK("rx_ps", pr, rx_ps)
        `CHK("tx_units", {1'b0, ut}, {tx_rs, tx_u})
        `CHK("tx_ps", pt, tx_ps)
        `CHK("rx_fixed", e[2], rx_fx)
        `CHK("tx_fixed", e[1], tx_fx)
        `CHK("mode", e[0], mode)
    endtask : chk_reg
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            fails++;
            end_sim();
        end
    end
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        chk_reg(16'h0E02);
        // Only the documented delay codes are programmed
        for (i = 0; i < 5; i++) begin
            v = {5'h01, i[0], ~i[0], codes[i], codes[4 - i], i[0], ~i[0], i[1]};
            wr(RGC_CFG_BYTEADDR, {16'hFFFF, 5'h1E, v[10:0]}, 4'hF, r);
            `CHK("bresp", RGC_RESP_OKAY, r)
            chk_reg(v);
        end
        wr(RGC_CFG_BYTEADDR, 32'h00000E07, 4'hF, r);
        wr(RGC_CFG_BYTEADDR, 32'h00000000, 4'h2, r);
        chk_reg(16'h0807);
        wr(18'h00000, 32'h0000FFFF, 4'hF, r);
        `CHK("bresp_unmapped", RGC_RESP_SLVERR, r)
        rd(18'h00004, d, r);
        `CHK("rresp_unmapped", {RGC_RESP_SLVERR, 32'h00000000}, {r, d})
        chk_reg(16'h0807);
        @(posedge clk);
        rst_n <= 1'b0;
        s_rx  <= 1'b1;
        s_tx  <= 1'b0;
        s_md  <= 1'b1;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        chk_reg(16'h0E05);
        end_sim();
    end
endmodule : rgc_config_bench
`default_nettype wire
